// >>> core/dtr_pkg.sv
package dtr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int MEAS_TIME_US    = 9600;
	// Longest time, so the division rounds down
	localparam int MEAS_CYC        = MEAS_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int STRAP_SETTLE_NS = 2000;
	// Least time, so round up
	localparam int STRAP_CYC       = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////////
	// Averaging
	localparam int AVG_COUNT = 16;
	localparam int AVG_LOG2  = 4;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] REG_EXT_FRAC   = 8'h06;
	localparam logic [7:0] REG_LOCAL_HIGH = 8'h0A;
	localparam logic [7:0] REG_REM1_HIGH  = 8'h0B;
	localparam logic [7:0] REG_REM2_HIGH  = 8'h0C;
	localparam logic [7:0] REG_BUS_ADDR   = 8'h0D;
	localparam logic [7:0] REG_UNMAPPED   = 8'h00;

	// Field positions in the fraction register
	localparam int EXT_REM1_LSB  = 0;
	localparam int EXT_REM2_LSB  = 3;
	localparam int EXT_LOCAL_LSB = 6;

	////////////////////////////////////////////////////////////////////////////////
	// Serial bus address
	localparam logic [4:0] BUS_ADDR_FIXED  = 5'h0B;
	localparam logic [1:0] STRAP_LOW_BITS  = 2'h0;
	localparam logic [1:0] STRAP_HIGH_BITS = 2'h1;
	localparam logic [1:0] STRAP_OPEN_BITS = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Converter channel codes
	localparam logic [1:0] CHAN_LOCAL = 2'h0;
	localparam logic [1:0] CHAN_REM1  = 2'h1;
	localparam logic [1:0] CHAN_REM2  = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// State encodings
	typedef enum logic [1:0] {
		SEQ_LOCAL    = 2'h0,
		SEQ_EXC_BASE = 2'h1,
		SEQ_EXC_MULT = 2'h3,
		SEQ_CONV     = 2'h2
	} dtr_seq_t;

	typedef enum logic [1:0] {
		STR_UP   = 2'h0,
		STR_DOWN = 2'h1,
		STR_DONE = 2'h3
	} dtr_strap_t;

endpackage

// >>> core/dtr_readout.sv
`timescale 1ns/1ns

module dtr_readout
	import dtr_pkg::*;
#(
	parameter int MEAS_CYCLES = MEAS_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	// Converter
	input  wire logic        adc_valid_i,
	input  wire logic [10:0] adc_data_i,
	output logic             adc_start_o,
	output logic [1:0]       adc_chan_o,
	output logic             exc_mult_o,
	output logic             reading_update_o,
	// Register read port
	input  wire logic [7:0]  reg_addr_i,
	output logic [7:0]       reg_rdata_o,
	// Address strap
	input  wire logic        strap_pin_i,
	output logic             strap_probe_o,
	output logic [6:0]       bus_addr_o,
	output logic             bus_addr_valid_o
);

	import dtr_pkg::*;

	localparam int CW  = $clog2(MEAS_CYCLES + 1);
	localparam int SW  = $clog2(STRAP_CYC + 1);
	localparam int ACW = 11 + AVG_LOG2;

	localparam logic [CW-1:0]       HALF_LAST  = CW'(MEAS_CYCLES / 2 - 1);
	localparam logic [SW-1:0]       STRAP_LAST = SW'(STRAP_CYC - 1);
	localparam logic [AVG_LOG2-1:0] CNT_LAST   = AVG_LOG2'(AVG_COUNT - 1);

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		dtr_seq_t                     seq;
		logic                         waiting;
		logic                         rem_sel;
		logic [CW-1:0]                timer;
		logic                         start;
		logic [1:0]                   chan;
		logic                         exc_mult;
		logic                         upd;
		logic [9:0]                   loc;
		logic [1:0][10:0]             rem;
		logic [1:0][ACW-1:0]          acc;
		logic [1:0][AVG_LOG2-1:0]     cnt;
		dtr_strap_t                   strap;
		logic [SW-1:0]                stimer;
		logic                         probe;
		logic                         samp_up;
		logic [6:0]                   bus_addr;
		logic                         addr_valid;
		logic [1:0]                   pin_sync;
		logic [7:0]                   rdata;
	} dtr_state_t;

	dtr_state_t s_q;
	dtr_state_t s_d;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Sign-extend an 11-bit result into the running sum
	function automatic logic [ACW-1:0] acc_add(
		input logic [ACW-1:0] acc,
		input logic [10:0]    d
	);
		acc_add = acc + {{AVG_LOG2{d[10]}}, d};
	endfunction

	// Divide the sum of 16 by shifting; truncation keeps the sign
	function automatic logic [10:0] avg_of(
		input logic [ACW-1:0] sum
	);
		avg_of = sum[ACW-1:AVG_LOG2];
	endfunction

	// Channel code for the selected remote diode
	function automatic logic [1:0] rem_chan(
		input logic sel
	);
		rem_chan = sel ? CHAN_REM2 : CHAN_REM1;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [ACW-1:0] sum;
		logic           rs;
		s_d   = s_q;
		sum   = '0;
		rs    = s_q.rem_sel;

		// Pulses last one cycle
		s_d.start = 1'b0;
		s_d.upd   = 1'b0;

		// Measurement sequencer: local, then one remote, alternating remotes
		unique case (s_q.seq)
			SEQ_LOCAL: begin
				if (!s_q.waiting) begin
					s_d.start   = 1'b1;
					s_d.chan    = CHAN_LOCAL;
					s_d.waiting = 1'b1;
				end else if (adc_valid_i) begin
					// Ten bits: high byte of degrees, two quarter-degree bits
					s_d.loc      = adc_data_i[9:0];
					s_d.upd      = 1'b1;
					s_d.waiting  = 1'b0;
					s_d.timer    = '0;
					s_d.exc_mult = 1'b0;
					s_d.seq      = SEQ_EXC_BASE;
				end
			end
			SEQ_EXC_BASE: begin
				// First half of the measurement on the base current
				if (s_q.timer == HALF_LAST) begin
					s_d.timer    = '0;
					s_d.exc_mult = 1'b1;
					s_d.seq      = SEQ_EXC_MULT;
				end else begin
					s_d.timer = s_q.timer + 1'b1;
				end
			end
			SEQ_EXC_MULT: begin
				// Second half on the multiplied current
				if (s_q.timer == HALF_LAST) begin
					s_d.timer    = '0;
					s_d.exc_mult = 1'b0;
					s_d.seq      = SEQ_CONV;
				end else begin
					s_d.timer = s_q.timer + 1'b1;
				end
			end
			SEQ_CONV: begin
				if (!s_q.waiting) begin
					s_d.start   = 1'b1;
					s_d.chan    = rem_chan(rs);
					s_d.waiting = 1'b1;
				end else if (adc_valid_i) begin
					// Eleven-bit signed result feeds the average
					sum = acc_add(s_q.acc[rs], adc_data_i);
					if (s_q.cnt[rs] == CNT_LAST) begin
						// Whole and fraction parts move in one write
						s_d.rem[rs] = avg_of(sum);
						s_d.acc[rs] = '0;
						s_d.cnt[rs] = '0;
						s_d.upd     = 1'b1;
					end else begin
						s_d.acc[rs] = sum;
						s_d.cnt[rs] = s_q.cnt[rs] + 1'b1;
					end
					s_d.waiting = 1'b0;
					s_d.rem_sel = ~rs;
					s_d.seq     = SEQ_LOCAL;
				end
			end
		endcase

		// Strap sensing: a floating pin follows the weak pull, a driven one does not
		s_d.pin_sync = {s_q.pin_sync[0], strap_pin_i};
		unique case (s_q.strap)
			STR_UP: begin
				s_d.probe = 1'b1;
				if (s_q.stimer == STRAP_LAST) begin
					s_d.samp_up = s_q.pin_sync[1];
					s_d.probe   = 1'b0;
					s_d.stimer  = '0;
					s_d.strap   = STR_DOWN;
				end else begin
					s_d.stimer = s_q.stimer + 1'b1;
				end
			end
			STR_DOWN: begin
				if (s_q.stimer == STRAP_LAST) begin
					// Both high: tied high; both low: tied low; else floating
					if (s_q.samp_up && s_q.pin_sync[1]) begin
						s_d.bus_addr = {BUS_ADDR_FIXED, STRAP_HIGH_BITS};
					end else if (!s_q.samp_up && !s_q.pin_sync[1]) begin
						s_d.bus_addr = {BUS_ADDR_FIXED, STRAP_LOW_BITS};
					end else begin
						s_d.bus_addr = {BUS_ADDR_FIXED, STRAP_OPEN_BITS};
					end
					s_d.addr_valid = 1'b1;
					s_d.strap      = STR_DONE;
				end else begin
					s_d.stimer = s_q.stimer + 1'b1;
				end
			end
			STR_DONE: begin
				// Held until the next reset; pin changes are ignored
				s_d.probe = 1'b0;
			end
			default: begin
				s_d.strap = STR_UP;
			end
		endcase

		// Register read, one cycle of latency
		unique case (reg_addr_i)
			REG_LOCAL_HIGH: s_d.rdata = s_q.loc[9:2];
			REG_REM1_HIGH:  s_d.rdata = s_q.rem[0][10:3];
			REG_REM2_HIGH:  s_d.rdata = s_q.rem[1][10:3];
			REG_EXT_FRAC: begin
				s_d.rdata = '0;
				s_d.rdata[EXT_REM1_LSB +: 3]  = s_q.rem[0][2:0];
				s_d.rdata[EXT_REM2_LSB +: 3]  = s_q.rem[1][2:0];
				s_d.rdata[EXT_LOCAL_LSB +: 2] = s_q.loc[1:0];
			end
			REG_BUS_ADDR:   s_d.rdata = {s_q.addr_valid, s_q.bus_addr};
			default:        s_d.rdata = REG_UNMAPPED;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	// Synchronous reset restarts the strap sample, standing in for power-up
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flops

	assign adc_start_o      = s_q.start;
	assign adc_chan_o       = s_q.chan;
	assign exc_mult_o       = s_q.exc_mult;
	assign reading_update_o = s_q.upd;
	assign reg_rdata_o      = s_q.rdata;
	assign strap_probe_o    = s_q.probe;
	assign bus_addr_o       = s_q.bus_addr;
	assign bus_addr_valid_o = s_q.addr_valid;

endmodule

// >>> dv/dtr_conv_model.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////////
// Converter and strap pin as seen from the far side
module dtr_conv_model
	import dtr_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Converter side
	input  wire logic        start_i,
	input  wire logic [1:0]  chan_i,
	output logic             valid_o,
	output logic [10:0]      data_o,
	// Values to measure
	input  wire logic [9:0]  loc_i,
	input  wire logic [10:0] r1_i,
	input  wire logic [10:0] r2_i,
	input  wire logic        alt_i,
	// Strap: 0 low, 1 high, 2 open
	input  wire logic [1:0]  strap_i,
	input  wire logic        probe_i,
	output logic             pin_o,
	output int               n_r2_o
);
	int          wait_q = -1;
	logic [10:0] v      = 11'h000;
	logic [1:0]  ch     = 2'h0;
	logic        slow   = 1'b0;
	logic        flip   = 1'b0;
	initial valid_o = 1'b0;
	initial data_o = 11'h000;
	initial n_r2_o = 0;
	// An open pin follows the weak pull
	assign pin_o = (strap_i == 2'h2) ? probe_i : strap_i[0];
	// Answers alternate fast and slow; idle data is inverted, never held
	always @(posedge clk_i) begin
		valid_o <= 1'b0;
		data_o <= ~v;
		if (rst_i) begin
			wait_q <= -1;
			n_r2_o <= 0;
		end else if (start_i) begin
			slow <= ~slow;
			wait_q <= slow ? 4 : 0;
			flip <= flip ^ (chan_i == CHAN_REM1);
			v <= (chan_i == CHAN_LOCAL) ? {~loc_i[9], loc_i}
				: ((chan_i == CHAN_REM1) ? r1_i : r2_i) + 11'(alt_i & flip);
			ch <= chan_i;
		end else if (wait_q > 0) begin
			wait_q <= wait_q - 1;
		end else if (wait_q == 0) begin
			valid_o <= 1'b1;
			data_o <= v;
			wait_q <= -1;
			n_r2_o <= n_r2_o + int'(ch == CHAN_REM2);
		end
	end
endmodule

// >>> dv/dtr_readout_chk.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////////
// Port checks of the readout block
module dtr_readout_chk
	import dtr_pkg::*;
#(
	parameter int MEAS_CYCLES = MEAS_CYC
) (
	input wire logic        sys_clk_i,
	input wire logic        sys_rst_i,
	input wire logic        adc_valid_i,
	input wire logic [10:0] adc_data_i,
	input wire logic        adc_start_o,
	input wire logic [1:0]  adc_chan_o,
	input wire logic        exc_mult_o,
	input wire logic        reading_update_o,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        strap_pin_i,
	input wire logic        strap_probe_o,
	input wire logic [6:0]  bus_addr_o,
	input wire logic        bus_addr_valid_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	int   hi_q   = 0;
	logic pend_q = 1'b0;
	// Length of the multiplied phase; a request stays open until its result
	always_ff @(posedge sys_clk_i) begin
		hi_q <= exc_mult_o ? hi_q + 1 : 0;
		pend_q <= !sys_rst_i && (adc_start_o || (pend_q && !adc_valid_i));
	end
	a_start_pulse: assert property (adc_start_o |=> !adc_start_o)
		else $error("start request longer than one cycle");
	a_exc_length: assert property ($fell(exc_mult_o) |-> hi_q == MEAS_CYCLES / 2)
		else $error("multiplied current phase has wrong length");
	a_remote_start: assert property ($fell(exc_mult_o) |=> adc_start_o && adc_chan_o != 2'h0)
		else $error("no remote conversion after excitation");
	a_update_cause: assert property (reading_update_o |-> $past(pend_q && adc_valid_i))
		else $error("reading published without a result");
	a_local_publish: assert property (pend_q && adc_valid_i && adc_chan_o == 2'h0
		|=> reading_update_o)
		else $error("local result not published");
	a_addr_prefix: assert property (bus_addr_valid_o |-> bus_addr_o[6:2] == 5'h0B
		&& bus_addr_o[1:0] != 2'h3)
		else $error("bus address outside the three choices");
	a_addr_frozen: assert property (bus_addr_valid_o |=> bus_addr_valid_o && $stable(bus_addr_o))
		else $error("bus address changed after decode");
	a_addr_timely: assert property ($fell(sys_rst_i) |-> ##[1:450] bus_addr_valid_o)
		else $error("strap not decoded in time");
	a_addr_read: assert property (!$past(sys_rst_i) && $past(reg_addr_i) == 8'h0D
		|-> reg_rdata_o == {$past(bus_addr_valid_o), $past(bus_addr_o)})
		else $error("bus address register disagrees with port");
	c_local: cover property (pend_q && adc_valid_i ##1 reading_update_o);
	c_exc: cover property ($fell(exc_mult_o));
	c_addr: cover property ($rose(bus_addr_valid_o));
endmodule
bind dtr_readout dtr_readout_chk #(.MEAS_CYCLES(MEAS_CYCLES)) dtr_readout_chk_i (.sys_clk_i,
	.sys_rst_i, .adc_valid_i, .adc_data_i, .adc_start_o, .adc_chan_o, .exc_mult_o,
	.reading_update_o, .reg_addr_i, .reg_rdata_o, .strap_pin_i, .strap_probe_o,
	.bus_addr_o, .bus_addr_valid_o);

// >>> dv/dtr_readout_bench.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////////
// Self-checking bench of the readout block
module dtr_readout_bench;
	import dtr_pkg::*;
	typedef struct {logic [9:0] loc; logic [10:0] r1, r2; logic alt; logic [1:0] st;
		logic [6:0] addr;} dtr_row_t;
	// Short measurement so that thirty-two passes, sixteen per remote, fit a short run
	localparam int MC = 20;
	logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, adc_valid_i, adc_start_o, exc_mult_o;
	logic reading_update_o, strap_pin_i, strap_probe_o, bus_addr_valid_o, alt;
	logic [10:0] adc_data_i, r1, r2;
	logic [9:0]  loc;
	logic [7:0]  reg_addr_i = 8'h00, reg_rdata_o;
	logic [6:0]  bus_addr_o;
	logic [1:0]  adc_chan_o, strap;
	int          n_errors = 0, cmp_count = 0, n_r2;
	dtr_row_t rows [4] = '{'{10'h000, 11'h000, 11'h000, 1'b0, 2'h0, 7'h2C},
		'{10'h3FF, 11'h7FF, 11'h3FE, 1'b0, 2'h1, 7'h2D},
		'{10'h200, 11'h400, 11'h3E9, 1'b0, 2'h2, 7'h2E},
		'{10'h065, 11'h7FF, 11'h0C9, 1'b1, 2'h2, 7'h2E}};
	always #(CLK_PERIOD_NS / 2) sys_clk_i = ~sys_clk_i;
	dtr_readout #(.MEAS_CYCLES(MC)) dtr_readout_i (.sys_clk_i, .sys_rst_i, .adc_valid_i,
		.adc_data_i, .adc_start_o, .adc_chan_o, .exc_mult_o, .reading_update_o,
		.reg_addr_i, .reg_rdata_o, .strap_pin_i, .strap_probe_o, .bus_addr_o,
		.bus_addr_valid_o);
	dtr_conv_model dtr_conv_model_i (.clk_i(sys_clk_i), .rst_i(sys_rst_i),
		.start_i(adc_start_o), .chan_i(adc_chan_o), .valid_o(adc_valid_i),
		.data_o(adc_data_i), .loc_i(loc), .r1_i(r1), .r2_i(r2), .alt_i(alt),
		.strap_i(strap), .probe_i(strap_probe_o), .pin_o(strap_pin_i), .n_r2_o(n_r2));
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// One register read, answered one edge later
	task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		reg_addr_i = a;
		@(posedge sys_clk_i);
		#1;
		cmp_count++;
		if (reg_rdata_o !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, reg_rdata_o);
		end
	endtask
	task automatic do_reset();
		sys_rst_i = 1'b1;
		repeat (12) @(posedge sys_clk_i);
		#1 sys_rst_i = 1'b0;
	endtask
	// Bounded wait for the sixteenth remote2 result to be published
	task automatic settle();
		for (int k = 0; k < 3000 && n_r2 < 16; k++) @(posedge sys_clk_i);
		if (n_r2 < 16) begin
			n_errors++;
			end_of_test();
		end
		repeat (3) @(posedge sys_clk_i);
		#1;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	// Table of readings, then the awkward cases
	initial begin
		foreach (rows[i]) begin
			{loc, r1, r2, alt, strap} = {rows[i].loc, rows[i].r1, rows[i].r2, rows[i].alt,
				rows[i].st};
			do_reset();
			rchk("local after reset", REG_LOCAL_HIGH, 8'h00);
			settle();
			rchk("local high", REG_LOCAL_HIGH, loc[9:2]);
			rchk("remote1 high", REG_REM1_HIGH, r1[10:3]);
			rchk("remote2 high", REG_REM2_HIGH, r2[10:3]);
			rchk("fraction", REG_EXT_FRAC, {loc[1:0], r2[2:0], r1[2:0]});
			rchk("bus address", REG_BUS_ADDR, {1'b1, rows[i].addr});
		end
		// Strap moved and remote input changed: nothing may follow yet
		strap = 2'h1;
		r1 = 11'h111;
		repeat (100) @(posedge sys_clk_i);
		#1;
		rchk("address held", REG_BUS_ADDR, 8'hAE);
		rchk("remote1 held", REG_REM1_HIGH, 8'hFF);
		rchk("unmapped", REG_UNMAPPED, 8'h00);
		end_of_test();
	end
endmodule
